// *** verilog/tmcmp_timer.sv ***
// 8-bit timer slice: counter, two compare units, output mux.
// Normal and clear-on-match modes only; PWM codes stop counting.
// Assumes all inputs synchronous to clk; strobes one cycle wide.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_timer
  import tmcmp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration
  input wire tmcmp_cfg_t cfg,
  input wire logic [7:0] compare_value_a,
  input wire logic [7:0] compare_value_b,
  // Counter write
  input wire logic count_write,
  input wire logic [7:0] count_write_data,
  // Force strobes
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  // Flag clears: interrupt acknowledge or write-one
  input wire tmcmp_flags_t flag_clear,
  // Port side
  input wire logic port_data_a,
  input wire logic port_data_b,
  input wire logic compare_pin_direction_bit_a,
  input wire logic compare_pin_direction_bit_b,
  // Status
  output logic [7:0] count_value,
  output tmcmp_flags_t flags,
  output logic compare_output_state_a,
  output logic compare_output_state_b,
  // Pins
  output logic pin_a,
  output logic pin_a_oe_n,
  output logic pin_b,
  output logic pin_b_oe_n
);

  typedef struct packed {
    logic [7:0] count;
    tmcmp_flags_t flags;
    logic oc_a;
    logic oc_b;
    logic match_a_pend;
    logic match_b_pend;
    logic block_match;
    logic pin_a;
    logic pin_a_oe_n;
    logic pin_b;
    logic pin_b_oe_n;
  } tmcmp_state_t;

  tmcmp_state_t st_reg;
  tmcmp_state_t st_next;
  logic tick;
  logic mux_a;
  logic mux_a_oe_n;
  logic mux_b;
  logic mux_b_oe_n;
  logic match_a;
  logic match_b;
  logic non_pwm;

  // ****************************************
  // Timer clock enable
  // ****************************************
  tmcmp_prescale u_prescale (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .timer_clock_select(cfg.timer_clock_select),
    .timer_clock_enable(tick)
  );

  // ****************************************
  // Pin override, from next register values
  // ****************************************
  tmcmp_pin_mux u_mux_a (
    .compare_output_mode(cfg.compare_output_mode_a),
    .compare_output_state(st_next.oc_a),
    .port_data(port_data_a),
    .compare_pin_direction_bit(compare_pin_direction_bit_a),
    .pin_value(mux_a),
    .pin_oe_n(mux_a_oe_n)
  );

  tmcmp_pin_mux u_mux_b (
    .compare_output_mode(cfg.compare_output_mode_b),
    .compare_output_state(st_next.oc_b),
    .port_data(port_data_b),
    .compare_pin_direction_bit(compare_pin_direction_bit_b),
    .pin_value(mux_b),
    .pin_oe_n(mux_b_oe_n)
  );

  always_comb begin
    st_next = st_reg;
    non_pwm = tmcmp_is_non_pwm(cfg.waveform_mode_select);
    // write blocks matches
    // PWM codes are refused here, so they raise no match at all
    match_a = non_pwm && (st_reg.count == compare_value_a) &&
              !st_reg.block_match;
    match_b = non_pwm && (st_reg.count == compare_value_b) &&
              !st_reg.block_match;

    // ****************************************
    // Counter
    // ****************************************
    if (tick) begin
      st_next.block_match = 1'b0;
      st_next.match_a_pend = match_a;
      st_next.match_b_pend = match_b;
      if (cfg.waveform_mode_select == WAVE_CLEAR_ON_MATCH && match_a) begin
        st_next.count = CNT_BOTTOM;
      end else if (non_pwm) begin
        st_next.count = st_reg.count + CNT_ONE;
        // max to zero
        // A write replaces the wrap, so no overflow then
        if (st_reg.count == CNT_MAX && !count_write) begin
          st_next.flags.overflow_flag = 1'b1;
        end
      end
      // Waveform output actions
      // action at match
      if (non_pwm && match_a) begin
        st_next.oc_a = tmcmp_action(cfg.compare_output_mode_a, st_reg.oc_a);
      end
      if (non_pwm && match_b) begin
        st_next.oc_b = tmcmp_action(cfg.compare_output_mode_b, st_reg.oc_b);
      end
      if (st_reg.match_a_pend) begin
        st_next.flags.compare_flag_a = 1'b1;
      end
      if (st_reg.match_b_pend) begin
        st_next.flags.compare_flag_b = 1'b1;
      end
    end

    if (count_write) begin
      st_next.count = count_write_data;
      st_next.block_match = 1'b1;
    end

    // ****************************************
    // Force compare
    // ****************************************
    // immediate action
    if (non_pwm && force_compare_a) begin
      st_next.oc_a = tmcmp_action(cfg.compare_output_mode_a, st_reg.oc_a);
    end
    if (non_pwm && force_compare_b) begin
      st_next.oc_b = tmcmp_action(cfg.compare_output_mode_b, st_reg.oc_b);
    end

    // ****************************************
    // Flag clears
    // ****************************************
    // acknowledge clears
    // Set wins over clear in the same cycle
    if (flag_clear.overflow_flag && !(tick && non_pwm && !count_write &&
        st_reg.count == CNT_MAX && !(cfg.waveform_mode_select ==
        WAVE_CLEAR_ON_MATCH && match_a))) begin
      st_next.flags.overflow_flag = 1'b0;
    end
    if (flag_clear.compare_flag_a && !(tick && st_reg.match_a_pend)) begin
      st_next.flags.compare_flag_a = 1'b0;
    end
    if (flag_clear.compare_flag_b && !(tick && st_reg.match_b_pend)) begin
      st_next.flags.compare_flag_b = 1'b0;
    end

    st_next.pin_a = mux_a;
    st_next.pin_a_oe_n = mux_a_oe_n;
    st_next.pin_b = mux_b;
    st_next.pin_b_oe_n = mux_b_oe_n;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.oc_a <= OUT_RESET;
      st_reg.oc_b <= OUT_RESET;
      st_reg.pin_a_oe_n <= 1'b1;
      st_reg.pin_b_oe_n <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign count_value = st_reg.count;
  assign flags = st_reg.flags;
  assign compare_output_state_a = st_reg.oc_a;
  assign compare_output_state_b = st_reg.oc_b;
  assign pin_a = st_reg.pin_a;
  assign pin_a_oe_n = st_reg.pin_a_oe_n;
  assign pin_b = st_reg.pin_b;
  assign pin_b_oe_n = st_reg.pin_b_oe_n;

endmodule
`default_nettype wire

// *** pkg/tmcmp_pkg.sv ***
// Package for the 8-bit timer slice: constants, modes and carriers.
// Assumes a single 20 MHz clock domain; no register bus, plain ports.
package tmcmp_pkg;

  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic OUT_RESET = 1'b0;

  // Waveform mode codes handled here
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_CLEAR_ON_MATCH = 3'h2;

  // Compare output mode codes in non-PWM modes
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Timer clock select codes
  localparam logic [2:0] CLK_STOP = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_DIV1024 = 3'h5;

  // Prescaler terminal counts (divide minus one)
  localparam int PRE_W = 10;
  localparam logic [9:0] PRE_DIV8_TC = 10'h007;
  localparam logic [9:0] PRE_DIV64_TC = 10'h03F;
  localparam logic [9:0] PRE_DIV256_TC = 10'h0FF;
  localparam logic [9:0] PRE_DIV1024_TC = 10'h3FF;

  typedef struct packed {
    logic [2:0] waveform_mode_select;
    logic [2:0] timer_clock_select;
    logic [1:0] compare_output_mode_a;
    logic [1:0] compare_output_mode_b;
  } tmcmp_cfg_t;

  typedef struct packed {
    logic overflow_flag;
    logic compare_flag_a;
    logic compare_flag_b;
  } tmcmp_flags_t;

  // Apply a non-PWM compare output action to a state bit
  function automatic logic tmcmp_action(input logic [1:0] mode,
                                        input logic cur);
    logic r;
    r = cur;
    case (mode)
      COM_TOGGLE: r = ~cur;
      COM_CLEAR: r = 1'b0;
      COM_SET: r = 1'b1;
      default: r = cur;
    endcase
    return r;
  endfunction

  function automatic logic tmcmp_is_non_pwm(input logic [2:0] wgm);
    return (wgm == WAVE_NORMAL) || (wgm == WAVE_CLEAR_ON_MATCH);
  endfunction

endpackage

// *** verilog/tmcmp_prescale.sv ***
// Timer clock enable generator from the I/O clock.
// Assumes clock_select is stable or changes on a clean edge.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_prescale
  import tmcmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic [2:0] timer_clock_select,
  // Enable out
  output logic timer_clock_enable
);

  typedef struct packed {
    logic [PRE_W-1:0] div;
  } tmcmp_pre_state_t;

  tmcmp_pre_state_t st_reg;
  tmcmp_pre_state_t st_next;
  logic [PRE_W-1:0] tc;

  always_comb begin
    st_next = st_reg;
    st_next.div = st_reg.div + PRE_W'(1);
    tc = PRE_DIV8_TC;
    timer_clock_enable = 1'b0;
    // ****************************************
    // Divider selection
    // ****************************************
    // selectable prescale
    case (timer_clock_select)
      CLK_DIV1: timer_clock_enable = 1'b1;
      CLK_DIV8: tc = PRE_DIV8_TC;
      CLK_DIV64: tc = PRE_DIV64_TC;
      CLK_DIV256: tc = PRE_DIV256_TC;
      CLK_DIV1024: tc = PRE_DIV1024_TC;
      default: tc = PRE_DIV8_TC;
    endcase
    if (timer_clock_select != CLK_DIV1 &&
        timer_clock_select != CLK_STOP &&
        timer_clock_select <= CLK_DIV1024) begin
      timer_clock_enable = ((st_reg.div & tc) == tc);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

// *** verilog/tmcmp_pin_mux.sv ***
// Port pin mux: compare output state overrides the port data bit.
// Assumes the port direction register sits outside this block.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_pin_mux
  import tmcmp_pkg::*;
(
  // Selection
  input wire logic [1:0] compare_output_mode,
  input wire logic compare_output_state,
  // Port side
  input wire logic port_data,
  input wire logic compare_pin_direction_bit,
  // Pin side
  output logic pin_value,
  output logic pin_oe_n
);

  always_comb begin
    pin_value = (compare_output_mode != COM_NONE) ?
                compare_output_state : port_data;
    pin_oe_n = ~compare_pin_direction_bit;
  end

endmodule
`default_nettype wire

// *** tb/tmcmp_pin_model.sv ***
// Pad model for one timer output pin, standing for the port pin.
// Assumes a pull-up on the pad while the timer does not drive it.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_pin_model (
  // Timer side
  input wire logic pin,
  input wire logic pin_oe_n,
  // Board side
  output logic pad
);
  assign pad = pin_oe_n ? 1'b1 : pin;
endmodule
`default_nettype wire

// *** tb/tmcmp_timer_assertions.sv ***
// Checker for the timer slice, bound into tmcmp_timer.
// Assumes the div-1 timer clock for the counting relations.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_timer_assertions
  import tmcmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic ce,
  input wire tmcmp_cfg_t cfg,
  input wire logic [7:0] compare_value_a,
  input wire logic count_write,
  input wire logic [7:0] count_write_data,
  input wire logic force_compare_a,
  input wire logic port_data_a,
  input wire logic [7:0] count_value,
  input wire tmcmp_flags_t flags,
  input wire logic compare_output_state_a,
  input wire logic pin_a
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************
  // Compare unit A
  // ****************
  sequence s_tick;
    ce && !count_write && cfg.timer_clock_select == CLK_DIV1;
  endsequence
  // Writes shadow the next tick, so both edges must be clean
  sequence s_match;
    ce && $past(ce) && !count_write && !$past(count_write) &&
    !force_compare_a && cfg.timer_clock_select == CLK_DIV1 &&
    tmcmp_is_non_pwm(cfg.waveform_mode_select) &&
    count_value == compare_value_a;
  endsequence
  property p_pin_a;
    $past(ce) && !$past(rst) |-> pin_a == ($past(cfg.compare_output_mode_a)
      != COM_NONE ? compare_output_state_a : $past(port_data_a));
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin A source");
  property p_write;
    ce && count_write |=> count_value == $past(count_write_data);
  endproperty
  a_write: assert property (p_write) else $error("count load");
  property p_norm;
    s_tick ##0 cfg.waveform_mode_select == WAVE_NORMAL
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_norm: assert property (p_norm) else $error("count step");
  property p_ovf;
    s_tick ##0 (count_value == CNT_MAX &&
      tmcmp_is_non_pwm(cfg.waveform_mode_select) &&
      !(cfg.waveform_mode_select == WAVE_CLEAR_ON_MATCH &&
      count_value == compare_value_a)) |=> flags.overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag");
  property p_ctc;
    s_match ##0 cfg.waveform_mode_select == WAVE_CLEAR_ON_MATCH
      |=> count_value == CNT_BOTTOM;
  endproperty
  a_ctc: assert property (p_ctc) else $error("top clear");
  property p_flag;
    s_match ##1 ce |=> flags.compare_flag_a;
  endproperty
  a_flag: assert property (p_flag) else $error("compare flag");
  property p_toggle;
    s_match ##0 cfg.compare_output_mode_a == COM_TOGGLE
      |=> compare_output_state_a != $past(compare_output_state_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle");
  property p_force;
    ce && force_compare_a && cfg.compare_output_mode_a[1] &&
      tmcmp_is_non_pwm(cfg.waveform_mode_select)
      |=> {1'b1, compare_output_state_a} == $past(cfg.compare_output_mode_a);
  endproperty
  a_force: assert property (p_force) else $error("force");
endmodule
bind tmcmp_timer tmcmp_timer_assertions u_chk (.clk, .rst, .ce, .cfg,
  .compare_value_a, .count_write, .count_write_data, .force_compare_a,
  .port_data_a, .count_value, .flags, .compare_output_state_a, .pin_a);
`default_nettype wire

// *** tb/tmcmp_timer_bench.sv ***
// Bench for the timer slice: random traffic against a cycle model.
// Assumes the div-1 timer clock while the model runs.
`timescale 1ns/10ps
`default_nettype none
module tmcmp_timer_bench;
  import tmcmp_pkg::*;
  logic clk, rst, ce, cw, frc_a, frc_b, pd_a, pd_b, dir_a, dir_b;
  logic st_a, st_b, pin_a, pin_b, oe_a, oe_b, pad_a, pad_b;
  logic [7:0] cva, cvb, wd, cnt;
  logic [31:0] seed, r, q;
  tmcmp_cfg_t cfg;
  tmcmp_flags_t clr, flags;
  bit run, m_ov, m_fa, m_fb, m_pa, m_pb, m_sa, m_sb, m_qa, m_qb, m_bk;
  bit m_ea, m_eb;
  int m_cnt, n_errors, compares;
  tmcmp_timer dut (.clk, .rst, .ce, .cfg, .compare_value_a(cva),
    .compare_value_b(cvb), .count_write(cw), .count_write_data(wd),
    .force_compare_a(frc_a), .force_compare_b(frc_b), .flag_clear(clr),
    .port_data_a(pd_a), .port_data_b(pd_b),
    .compare_pin_direction_bit_a(dir_a), .compare_pin_direction_bit_b(dir_b),
    .count_value(cnt), .flags, .compare_output_state_a(st_a),
    .compare_output_state_b(st_b), .pin_a, .pin_a_oe_n(oe_a), .pin_b,
    .pin_b_oe_n(oe_b));
  tmcmp_pin_model u_pad_a (.pin(pin_a), .pin_oe_n(oe_a), .pad(pad_a));
  tmcmp_pin_model u_pad_b (.pin(pin_b), .pin_oe_n(oe_b), .pad(pad_b));
  // ****************
  // Model and checks
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bit act(logic [1:0] com, bit s);
    return com == 2'h1 ? !s : com == 2'h0 ? s : com[0];
  endfunction
  task automatic step();
    bit np, clear_on_match_mode, ma, mb;
    np = cfg.waveform_mode_select inside {WAVE_NORMAL, WAVE_CLEAR_ON_MATCH};
    clear_on_match_mode = cfg.waveform_mode_select == WAVE_CLEAR_ON_MATCH;
    ma = np && !m_bk && m_cnt == cva;
    mb = np && !m_bk && m_cnt == cvb;
    m_ov = (np && !cw && m_cnt == 255 && !(clear_on_match_mode && ma)) || (m_ov && !clr[2]);
    m_fa = m_pa || (m_fa && !clr[1]);
    m_fb = m_pb || (m_fb && !clr[0]);
    m_pa = ma;
    m_pb = mb;
    m_cnt = cw ? wd : !np ? m_cnt : (clear_on_match_mode && ma) ? 0 : (m_cnt + 1) & 32'hFF;
    if (np && (ma || frc_a)) m_sa = act(cfg.compare_output_mode_a, m_sa);
    if (np && (mb || frc_b)) m_sb = act(cfg.compare_output_mode_b, m_sb);
    m_qa = cfg.compare_output_mode_a != 2'h0 ? m_sa : pd_a;
    m_qb = cfg.compare_output_mode_b != 2'h0 ? m_sb : pd_b;
    {m_ea, m_eb, m_bk} = {!dir_a, !dir_b, cw};
  endtask
  task chk_cnt(logic [10:0] g, logic [10:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: count %h expected %h", $time, g, e);
    end
  endtask
  task chk_bit(logic [10:0] g, logic [10:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: status %b expected %b", $time, g, e);
    end
  endtask
  task results();
    $display("Errors %0d in %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic prescale(int k);
    int t, e;
    logic [7:0] c0;
    cfg.timer_clock_select = k[2:0];
    repeat (2) begin
      c0 = cnt;
      t = 0;
      while (cnt === c0 && t < 2100) begin
        @(negedge clk);
        t++;
      end
    end
    e = k == 4 ? 256 : k == 5 ? 1024 : 1 << (3 * k - 3);
    chk_cnt(t[10:0], e[10:0]); // tick spacing
  endtask
  always @(posedge clk) begin
    if (rst) begin
      {m_ov, m_fa, m_fb, m_pa, m_pb, m_sa, m_sb, m_qa, m_qb, m_bk} = '0;
      {m_ea, m_eb, m_cnt} = {2'h3, 32'h0};
    end else if (run && ce) begin
      step();
    end
  end
  always @(negedge clk) begin
    if (run) begin
      chk_cnt({3'h0, cnt}, m_cnt[10:0]); // counter
      chk_bit({flags, st_a, st_b, pin_a, pin_b, oe_a, oe_b, pad_a, pad_b},
        {m_ov, m_fa, m_fb, m_sa, m_sb, m_qa, m_qb, m_ea, m_eb, m_ea | m_qa,
        m_eb | m_qb}); // outputs
      r = rnd();
      q = rnd();
      {ce, cw, frc_a, frc_b} = {r[3:0] != 0, r[9:4] == 0, r[13:10] == 0,
        r[17:14] == 0};
      {wd, clr, pd_a, pd_b} = {q[7:0], r[20:18] & {3{r[21]}}, r[23:22]};
      if (r[29:24] == 6'h00) begin
        cfg.waveform_mode_select = q[11:8] == 0 ? 3'h3 : {1'h0, q[12], 1'h0};
        {cfg.compare_output_mode_a, cfg.compare_output_mode_b} = q[16:13];
        {cva, cvb, dir_a, dir_b} = {2'h0, q[22:17], q[30:23], q[31], q[8]};
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(12000 * 50);
    n_errors++;
    results();
  end
  initial begin
    {seed, rst, run, n_errors, compares} = {32'hBC96, 2'h2, 64'h0};
    {ce, cw, frc_a, frc_b, pd_a, pd_b, dir_a, dir_b} = 8'h83;
    {wd, clr, cva, cvb} = {8'h00, 3'h0, 8'h05, 8'h0A};
    cfg = '{WAVE_CLEAR_ON_MATCH, CLK_DIV1, COM_TOGGLE, COM_SET};
    repeat (4) @(negedge clk);
    #5 {rst, run} = 2'h1;
    repeat (3000) @(negedge clk);
    #5 rst = 1'b1;
    repeat (2) @(negedge clk);
    #5 rst = 1'b0;
    repeat (3000) @(negedge clk);
    #5 run = 1'b0;
    {ce, cw, frc_a, frc_b} = 4'h8;
    cfg.waveform_mode_select = WAVE_NORMAL;
    for (int k = 1; k < 6; k++) prescale(k);
    cfg.timer_clock_select = CLK_STOP;
    {wd, cw} = {8'h5A, 1'h1};
    @(negedge clk);
    cw = 1'b0;
    repeat (40) @(negedge clk);
    chk_cnt({3'h0, cnt}, 11'h05A); // stopped but loaded
    results();
  end
endmodule
`default_nettype wire
